//--- logic/spg_config_bank.sv
// Configuration bank for the third and fourth high-side switches, two
// general-purpose pins, two PWM generators and a host scratch byte.
// Assumes synchronous mode pulses (soft reset, restart entry) and fault levels
// from the rest of the chip, and an AXI4-Lite master on the register port.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Behaviour
// (R1) One register holds third switch source in 2:0, fourth in 6:4.
// (R2) Overcurrent or overtemperature on a switch clears its source to off.
// (R3) Reserved bits read as zero and ignore writes.
// (R4) Third fault output duty: 20, 10, 5 or 2.5 percent by bits 7:6.
// (R5) Each pin has a 3-bit function: fault out, off, low or high switch.
// (R6) Code 101 makes the pin a wake input with 16 us static filter.
// (R7) Host assigns the matching timer to a switch when using cyclic sense.
// (R8) PWM duty 0 is off, 255 is on, else on for duty/255.
// (R9) Second PWM has its own 8-bit duty register, same encoding.
// (R10) Rate bit 0 and bit 2 pick 200 Hz or 400 Hz per generator.
// (R11) Switch source register clears on power-on, soft reset and restart.
// (R12) Pin and duty registers clear on power-on and soft reset, keep on restart.
// (R13) Rate register clears on power-on and soft reset, keeps bits on restart.
// (R14) Scratch byte clears only at power-on, survives soft reset.
// (R15) Scratch byte survives fail-safe and restart.
// (R16) Scratch access only in normal mode; logic never alters it.
// (R17) Each PWM period counts 255 steps, output on while step below duty.
module spg_config_bank #(
  parameter int unsigned PWM_LOW_STEP_CYC = spg_pkg::PWM_LOW_STEP_CYC,
  parameter int unsigned PWM_HIGH_STEP_CYC = spg_pkg::PWM_HIGH_STEP_CYC,
  parameter int unsigned WAKE_CYC = spg_pkg::WAKE_CYC,
  parameter int unsigned FO_STEP_CYC = spg_pkg::FO_STEP_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic restart_entry_i,
  input wire logic normal_mode_i,
  input wire logic [1:0] switch_fault_i,
  input wire logic timer_one_i,
  input wire logic timer_two_i,
  input wire logic second_fault_i,
  input wire logic third_fault_i,
  input wire logic [1:0] pin_in_i,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe_o,
  output logic [1:0] pin_wake_o,
  output logic third_switch_o,
  output logic fourth_switch_o,
  output logic [1:0] pwm_o,
  input wire logic [spg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [spg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Prescaler and filter counters are 16 bits wide
  if (PWM_LOW_STEP_CYC < 1 || PWM_LOW_STEP_CYC > 65535 || PWM_HIGH_STEP_CYC < 1 ||
      PWM_HIGH_STEP_CYC > 65535 || WAKE_CYC < 1 || WAKE_CYC > 65535 ||
      FO_STEP_CYC < 1 || FO_STEP_CYC > 65535)
  begin : gen_bad_param
    $error("spg_config_bank: counts must lie in 1..65535");
  end

  logic aw_hold_q;
  logic w_hold_q;
  logic [5:0] wr_idx_q;
  logic [7:0] wr_data_q;
  logic wr_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;
  logic wr_hit;
  logic wr_en;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [5:0] rd_idx;
  logic [2:0] third_src_q;
  logic [2:0] fourth_src_q;
  logic [7:0] pin_fn_q;
  logic [7:0] duty_q [2];
  logic [1:0] rate_q;
  logic [7:0] scratch_q;
  logic [15:0] pwm_pre_q [2];
  logic [7:0] pwm_step_q [2];
  logic [1:0] pwm_q;
  logic [15:0] fo_pre_q;
  logic [5:0] fo_step_q;
  logic fo_blink;
  logic [1:0] fault_level;
  logic [15:0] wake_cnt_q [2];
  logic [1:0] wake_q;
  logic [1:0] pin_q;
  logic [1:0] pin_oe_q;
  logic third_sw_q;
  logic fourth_sw_q;
  logic [7:0] fo_on_steps;

  // Write channel: address and data taken in either order, one write at a time
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign do_write = aw_hold_q && w_hold_q;
  assign wr_en = do_write && wr_hit && wr_lane_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      wr_idx_q <= 6'h00;
      wr_data_q <= 8'h00;
      wr_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= spg_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        wr_idx_q <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wr_data_q <= s_axi_wdata[7:0];
        wr_lane_q <= s_axi_wstrb[0]; // Upper lanes hold only zeros
      end
      if (do_write)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? spg_pkg::RESP_OKAY : spg_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Write decode; scratch writes outside normal mode are dropped but answered
  always_comb
  begin
    unique case (wr_idx_q)
      spg_pkg::IDX_SW_SRC, spg_pkg::IDX_PIN_FN, spg_pkg::IDX_PWM_ONE,
      spg_pkg::IDX_PWM_TWO, spg_pkg::IDX_PWM_FREQ, spg_pkg::IDX_SCRATCH: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read mux; reserved bits and upper lanes read zero
  assign rd_idx = s_axi_araddr[7:2];
  always_comb
  begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    unique case (rd_idx)
      spg_pkg::IDX_SW_SRC: rd_byte = {1'b0, fourth_src_q, 1'b0, third_src_q}; // R1 R3
      spg_pkg::IDX_PIN_FN: rd_byte = pin_fn_q;
      spg_pkg::IDX_PWM_ONE: rd_byte = duty_q[0];
      spg_pkg::IDX_PWM_TWO: rd_byte = duty_q[1]; // R9
      spg_pkg::IDX_PWM_FREQ: rd_byte = {5'b0_0000, rate_q[1], 1'b0, rate_q[0]}; // R3
      spg_pkg::IDX_SCRATCH: rd_byte = normal_mode_i ? scratch_q : 8'h00; // R16
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel: answer one cycle after address is taken
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= spg_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? spg_pkg::RESP_OKAY : spg_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // Switch sources; a fault beats a same-cycle write, safety first
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      third_src_q <= spg_pkg::SW_SRC_RST[2:0];
      fourth_src_q <= spg_pkg::SW_SRC_RST[6:4];
    end
    else if (soft_reset_i || restart_entry_i)
    begin
      third_src_q <= spg_pkg::SW_SRC_RST[2:0]; // R11
      fourth_src_q <= spg_pkg::SW_SRC_RST[6:4]; // R11
    end
    else
    begin
      if (switch_fault_i[0])
        third_src_q <= spg_pkg::SPG_SRC_OFF; // R2
      else if (wr_en && wr_idx_q == spg_pkg::IDX_SW_SRC)
        third_src_q <= wr_data_q[spg_pkg::THIRD_SRC_LSB +: spg_pkg::SRC_W]; // R1
      if (switch_fault_i[1])
        fourth_src_q <= spg_pkg::SPG_SRC_OFF; // R2
      else if (wr_en && wr_idx_q == spg_pkg::IDX_SW_SRC)
        fourth_src_q <= wr_data_q[spg_pkg::FOURTH_SRC_LSB +: spg_pkg::SRC_W]; // R1
    end
  end

  // Pin function and duty registers; restart leaves them alone
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_fn_q <= spg_pkg::PIN_FN_RST;
      duty_q[0] <= spg_pkg::DUTY_RST;
      duty_q[1] <= spg_pkg::DUTY_RST;
    end
    else if (soft_reset_i)
    begin
      pin_fn_q <= spg_pkg::PIN_FN_RST; // R12
      duty_q[0] <= spg_pkg::DUTY_RST; // R12
      duty_q[1] <= spg_pkg::DUTY_RST; // R12
    end
    else if (wr_en)
    begin
      if (wr_idx_q == spg_pkg::IDX_PIN_FN)
        pin_fn_q <= wr_data_q; // R5
      if (wr_idx_q == spg_pkg::IDX_PWM_ONE)
        duty_q[0] <= wr_data_q;
      if (wr_idx_q == spg_pkg::IDX_PWM_TWO)
        duty_q[1] <= wr_data_q; // R9
    end
  end

  // Rate select bits; only the two live bits are stored
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rate_q <= spg_pkg::RATE_RST;
    else if (soft_reset_i)
      rate_q <= spg_pkg::RATE_RST; // R13
    else if (wr_en && wr_idx_q == spg_pkg::IDX_PWM_FREQ)
      rate_q <= {wr_data_q[spg_pkg::SECOND_RATE_BIT], wr_data_q[spg_pkg::FIRST_RATE_BIT]}; // R10
  end

  // Scratch byte: power-on clear only, host access only in normal mode
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      scratch_q <= spg_pkg::SCRATCH_RST; // R14
    else if (wr_en && wr_idx_q == spg_pkg::IDX_SCRATCH && normal_mode_i)
      scratch_q <= wr_data_q; // R15 R16
  end

  // PWM generators: prescaler then 255-step counter per generator
  for (genvar g = 0; g < 2; g++)
  begin : gen_pwm
    logic [15:0] pre_last;
    assign pre_last = rate_q[g] ? 16'(PWM_HIGH_STEP_CYC - 1) : 16'(PWM_LOW_STEP_CYC - 1); // R10
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        pwm_pre_q[g] <= 16'h0000;
        pwm_step_q[g] <= 8'h00;
        pwm_q[g] <= 1'b0;
      end
      else
      begin
        // Greater-or-equal so a rate change mid-step cannot overrun
        if (pwm_pre_q[g] >= pre_last)
        begin
          pwm_pre_q[g] <= 16'h0000;
          pwm_step_q[g] <= (pwm_step_q[g] == spg_pkg::PWM_LAST_STEP) ? 8'h00 :
                           pwm_step_q[g] + 8'h01; // R17
        end
        else
        begin
          pwm_pre_q[g] <= pwm_pre_q[g] + 16'h0001;
        end
        // Step never reaches 255, so duty 255 is always on and 0 always off
        pwm_q[g] <= pwm_step_q[g] < duty_q[g]; // R8 R17
      end
    end
  end
  assign pwm_o = pwm_q;

  // Fault blink for the third fault output, 40 steps per period
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fo_pre_q <= 16'h0000;
      fo_step_q <= 6'h00;
    end
    else if (fo_pre_q == 16'(FO_STEP_CYC - 1))
    begin
      fo_pre_q <= 16'h0000;
      fo_step_q <= (fo_step_q == spg_pkg::FO_LAST_STEP) ? 6'h00 : fo_step_q + 6'h01;
    end
    else
    begin
      fo_pre_q <= fo_pre_q + 16'h0001;
    end
  end
  assign fo_on_steps = {2'b00, 6'(spg_pkg::FO_ON_STEPS >> (6 * pin_fn_q[spg_pkg::FO_DUTY_LSB +: 2]))};
  assign fo_blink = {2'b00, fo_step_q} < fo_on_steps; // R4
  assign fault_level = {third_fault_i && fo_blink, second_fault_i};

  // Pin functions and wake filters, one per pin
  for (genvar p = 0; p < 2; p++)
  begin : gen_pin
    logic [2:0] fn;
    assign fn = pin_fn_q[3*p +: spg_pkg::PIN_W];
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        pin_q[p] <= 1'b0;
        pin_oe_q[p] <= 1'b0;
      end
      else
      begin
        unique case (fn)
          spg_pkg::PIN_OFF, spg_pkg::PIN_WAKE:
          begin
            pin_q[p] <= 1'b0;
            pin_oe_q[p] <= 1'b0;
          end
          spg_pkg::PIN_LOW_ON:
          begin
            pin_q[p] <= 1'b0; // R5
            pin_oe_q[p] <= 1'b1;
          end
          spg_pkg::PIN_HIGH_ON:
          begin
            pin_q[p] <= 1'b1; // R5
            pin_oe_q[p] <= 1'b1;
          end
          default:
          begin
            pin_q[p] <= fault_level[p]; // R4 R5
            pin_oe_q[p] <= 1'b1;
          end
        endcase
      end
    end
    // Static filter: level must differ from accepted one for the full time
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        wake_cnt_q[p] <= 16'h0000;
        wake_q[p] <= 1'b0;
      end
      else if (fn != spg_pkg::PIN_WAKE || pin_in_i[p] == wake_q[p])
      begin
        wake_cnt_q[p] <= 16'h0000;
        if (fn != spg_pkg::PIN_WAKE)
          wake_q[p] <= 1'b0;
      end
      else if (wake_cnt_q[p] == 16'(WAKE_CYC - 1))
      begin
        wake_cnt_q[p] <= 16'h0000;
        wake_q[p] <= pin_in_i[p]; // R6
      end
      else
      begin
        wake_cnt_q[p] <= wake_cnt_q[p] + 16'h0001;
      end
    end
  end
  assign pin_o = pin_q;
  assign pin_oe_o = pin_oe_q;
  assign pin_wake_o = wake_q;

  // Switch drive from the selected source; reserved codes keep it off
  function automatic logic src_drive(input logic [2:0] src, input logic [1:0] pwm);
    unique case (src)
      spg_pkg::SPG_SRC_ON: src_drive = 1'b1;
      spg_pkg::SPG_SRC_TIMER_ONE: src_drive = timer_one_i;
      spg_pkg::SPG_SRC_TIMER_TWO: src_drive = timer_two_i; // R7
      spg_pkg::SPG_SRC_PWM_ONE: src_drive = pwm[0];
      spg_pkg::SPG_SRC_PWM_TWO: src_drive = pwm[1];
      default: src_drive = 1'b0;
    endcase
  endfunction

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      third_sw_q <= 1'b0;
      fourth_sw_q <= 1'b0;
    end
    else
    begin
      third_sw_q <= src_drive(third_src_q, pwm_q); // R1
      fourth_sw_q <= src_drive(fourth_src_q, pwm_q); // R1
    end
  end
  assign third_switch_o = third_sw_q;
  assign fourth_switch_o = fourth_sw_q;

  // Checks on the bank's own behaviour
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  localparam int WAKE_LAST = int'(WAKE_CYC) - 1;

  switch_on_code_a: assert property (third_src_q == spg_pkg::SPG_SRC_ON |=> third_sw_q) // R1
    else $error("third switch not driven by on code");
  fault_clears_src_a: assert property (switch_fault_i[1] |=> fourth_src_q == 3'b000) // R2
    else $error("fault did not clear fourth switch source");
  reserved_reads_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000 &&
    !(rdata_q[7] && $past(rd_idx) == spg_pkg::IDX_SW_SRC)) // R3
    else $error("reserved bits read nonzero");
  low_side_pin_a: assert property (gen_pin[1].fn == spg_pkg::PIN_LOW_ON |=> pin_oe_o[1] && !pin_o[1]) // R5
    else $error("low-side pin function not driven");
  wake_filter_time_a: assert property ($changed(wake_q[0]) && gen_pin[0].fn == spg_pkg::PIN_WAKE
    |-> $past(wake_cnt_q[0]) == WAKE_LAST) // R6
    else $error("wake accepted before filter time");
  duty_zero_off_a: assert property (duty_q[1] == 8'h00 |=> !pwm_o[1]) // R8
    else $error("duty zero output not off");
  duty_full_on_a: assert property (duty_q[0] == 8'hff |=> pwm_o[0]) // R8
    else $error("full duty output not on");
  step_wraps_a: assert property (pwm_step_q[0] == spg_pkg::PWM_LAST_STEP &&
    pwm_pre_q[0] >= gen_pwm[0].pre_last |=> pwm_step_q[0] == 8'h00) // R17
    else $error("PWM step count does not wrap after 255 steps");
  restart_clears_src_a: assert property (restart_entry_i |=> third_src_q == 3'b000 &&
    fourth_src_q == 3'b000) // R11
    else $error("restart did not clear switch sources");
  restart_keeps_cfg_a: assert property (restart_entry_i && !soft_reset_i && !wr_en
    |=> $stable(pin_fn_q) && $stable(duty_q[0]) && $stable(rate_q)) // R12 R13
    else $error("restart changed kept configuration");
  soft_reset_clears_a: assert property (soft_reset_i |=> rate_q == 2'b00 && duty_q[1] == 8'h00) // R12 R13
    else $error("soft reset did not clear configuration");
  scratch_guarded_a: assert property (!(wr_en && wr_idx_q == spg_pkg::IDX_SCRATCH &&
    normal_mode_i) |=> $stable(scratch_q)) // R14 R15 R16
    else $error("scratch byte changed outside host write in normal mode");

  cover_scratch_write: cover property (wr_en && wr_idx_q == spg_pkg::IDX_SCRATCH && normal_mode_i);
  cover_fault_clear: cover property (third_src_q != 3'b000 ##1 third_src_q == 3'b000);
  cover_pwm_toggle: cover property ($rose(pwm_o[0]) ##[1:1000] $fell(pwm_o[0]));
  cover_wake_seen: cover property ($rose(pin_wake_o[1]));

endmodule

//--- logic/spg_pkg.sv
// Constants for the switch, PWM and general-purpose pin configuration bank.
// Assumes a 100 MHz system clock and an AXI4-Lite register port, 32-bit data.
package spg_pkg;

  // System clock
  localparam int unsigned CLK_HZ = 100_000_000;

  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W = 8;
  localparam logic [5:0] IDX_SW_SRC = 6'h15;
  localparam logic [5:0] IDX_PIN_FN = 6'h17;
  localparam logic [5:0] IDX_PWM_ONE = 6'h18;
  localparam logic [5:0] IDX_PWM_TWO = 6'h19;
  localparam logic [5:0] IDX_PWM_FREQ = 6'h1c;
  localparam logic [5:0] IDX_SCRATCH = 6'h1e;

  // Field positions
  localparam int unsigned SRC_W = 3;
  localparam int unsigned THIRD_SRC_LSB = 0;
  localparam int unsigned FOURTH_SRC_LSB = 4;
  localparam int unsigned PIN_W = 3;
  localparam int unsigned FIRST_PIN_LSB = 0;
  localparam int unsigned SECOND_PIN_LSB = 3;
  localparam int unsigned FO_DUTY_LSB = 6;
  localparam int unsigned FIRST_RATE_BIT = 0;
  localparam int unsigned SECOND_RATE_BIT = 2;

  // Reset values
  localparam logic [7:0] SW_SRC_RST = 8'h00;
  localparam logic [7:0] PIN_FN_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [1:0] RATE_RST = 2'b00;
  localparam logic [7:0] SCRATCH_RST = 8'h00;

  // Switch source codes
  typedef enum logic [2:0] {
    SPG_SRC_OFF = 3'b000,
    SPG_SRC_ON = 3'b001,
    SPG_SRC_TIMER_ONE = 3'b010,
    SPG_SRC_TIMER_TWO = 3'b011,
    SPG_SRC_PWM_ONE = 3'b100,
    SPG_SRC_PWM_TWO = 3'b101
  } spg_src_t;

  // Pin function codes; 000 to 011 all select the fault output
  localparam logic [2:0] PIN_OFF = 3'b100;
  localparam logic [2:0] PIN_WAKE = 3'b101;
  localparam logic [2:0] PIN_LOW_ON = 3'b110;
  localparam logic [2:0] PIN_HIGH_ON = 3'b111;

  // PWM timing: 255 steps per period
  localparam int unsigned PWM_STEPS = 255;
  localparam logic [7:0] PWM_LAST_STEP = 8'hfe;
  localparam int unsigned PWM_LOW_HZ = 200;
  localparam int unsigned PWM_HIGH_HZ = 400;
  localparam int unsigned PWM_LOW_STEP_CYC = CLK_HZ / (PWM_LOW_HZ * PWM_STEPS);
  localparam int unsigned PWM_HIGH_STEP_CYC = CLK_HZ / (PWM_HIGH_HZ * PWM_STEPS);

  // Wake input static filter, a least time; 1600 cycles, exact at 100 MHz
  localparam int unsigned WAKE_FILTER_US = 16;
  localparam int unsigned WAKE_CYC = (WAKE_FILTER_US * (CLK_HZ / 1_000_000));

  // Fault output blink: 40 steps, on for 8, 4, 2 or 1 of them
  localparam logic [5:0] FO_LAST_STEP = 6'h27;
  localparam int unsigned FO_STEP_CYC = 100;
  localparam logic [23:0] FO_ON_STEPS = 24'h04_2108;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

//--- tb/spg_config_bank_tb.sv
// Self-checking bench for the switch, PWM and pin configuration bank.
// Assumes shortened step counts and the host model as the only bus master.
`timescale 1ns/1ps
module spg_config_bank_tb;
  logic mclk_i, reset_n_i, soft_reset_i, restart_entry_i, normal_mode_i;
  logic timer_one_i, timer_two_i, second_fault_i, third_fault_i, third_switch_o, fourth_switch_o;
  logic [1:0] switch_fault_i, pin_in_i, pin_o, pin_oe_o, pin_wake_o, pwm_o, s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr, s_axi_araddr, m;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] resp;
  logic [2:0] prot;
  logic [3:0] wstrb;
  int error_cnt, comparisons, n1, n2;
  localparam logic [7:0] ADR [6] = '{8'h54, 8'h5c, 8'h60, 8'h64, 8'h70, 8'h78};
  localparam logic [7:0] PIN_CFG [4] = '{8'h7c, 8'h37, 8'h20, 8'h2d};
  localparam logic [3:0] PIN_EXP [4] = '{4'ha, 4'hd, 4'h5, 4'h0};
  localparam logic [1:0] OKAY = spg_pkg::RESP_OKAY;

  spg_config_bank #(.PWM_LOW_STEP_CYC(4), .PWM_HIGH_STEP_CYC(2), .WAKE_CYC(8),
    .FO_STEP_CYC(2)) spg_config_bank_inst (
    .mclk_i, .reset_n_i, .soft_reset_i, .restart_entry_i, .normal_mode_i, .switch_fault_i,
    .timer_one_i, .timer_two_i, .second_fault_i, .third_fault_i, .pin_in_i, .pin_o, .pin_oe_o,
    .pin_wake_o, .third_switch_o, .fourth_switch_o, .pwm_o, .s_axi_awaddr, .s_axi_awprot(prot),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(wstrb), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(prot), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  spg_host_model spg_host_model_inst (
    .mclk_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial
  begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    begin
      comparisons++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    begin
      spg_host_model_inst.wr(a, {24'h0, d}, resp);
      chk({30'h0, resp}, {30'h0, er}, "write response");
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    begin
      spg_host_model_inst.rd(a, rdat, resp);
      chk(rdat, {24'h0, ed}, "read data");
      chk({30'h0, resp}, {30'h0, er}, "read response");
    end
  endtask

  // Expected bytes packed switch source first, scratch last
  task automatic rd_all(input logic [47:0] e);
    for (int i = 0; i < 6; i++)
      rd(ADR[i], e[8*(5-i) +: 8], OKAY);
  endtask

  task automatic wrap_up();
    begin
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Main sequence
  initial
  begin
    {reset_n_i, soft_reset_i, restart_entry_i, timer_one_i, timer_two_i} = '0;
    {second_fault_i, third_fault_i, switch_fault_i, pin_in_i} = '0;
    normal_mode_i = 1'h1;
    {prot, wstrb} = 7'h0f;
    error_cnt = 0;
    comparisons = 0;
    cyc(12);
    reset_n_i <= 1'h1;
    rd_all(48'h0);
    wr(ADR[0], 8'hff, OKAY);
    rd(ADR[0], 8'h77, OKAY);
    wr(ADR[4], 8'hff, OKAY);
    rd(ADR[4], 8'h05, OKAY);
    $display("test reserved bits done");
    // Every source code, once with timer one and PWM one high, once with the others
    for (int p = 0; p < 2; p++)
    begin
      timer_one_i <= (p == 0);
      timer_two_i <= (p == 1);
      m = (p == 0) ? 8'h16 : 8'h2a;
      wr(ADR[2], (p == 0) ? 8'hff : 8'h00, OKAY);
      wr(ADR[3], (p == 0) ? 8'h00 : 8'hff, OKAY);
      for (int c = 0; c < 8; c++)
      begin
        wr(ADR[0], {1'h0, c[2:0], 1'h0, c[2:0]}, OKAY);
        cyc(3);
        @(negedge mclk_i);
        chk({30'h0, third_switch_o, fourth_switch_o}, {30'h0, {2{m[c]}}}, "switch");
        chk({30'h0, pwm_o}, (p == 0) ? 32'h1 : 32'h2, "pwm level");
      end
    end
    $display("test switch sources done");
    wr(ADR[0], 8'h11, OKAY);
    switch_fault_i <= 2'h1;
    cyc(2);
    rd(ADR[0], 8'h10, OKAY);
    switch_fault_i <= 2'h2;
    cyc(2);
    switch_fault_i <= 2'h0;
    rd(ADR[0], 8'h00, OKAY);
    $display("test switch fault done");
    // Mid duty; second generator at the fast rate
    wr(ADR[2], 8'h40, OKAY);
    wr(ADR[3], 8'h40, OKAY);
    wr(ADR[4], 8'h04, OKAY);
    cyc(1020);
    {n1, n2} = '0;
    for (int k = 0; k < 1020; k++)
    begin
      @(negedge mclk_i);
      n1 += pwm_o[0];
      n2 += (k < 510) ? pwm_o[1] : 0;
    end
    chk(n1, 256, "first pwm on time");
    chk(n2, 128, "second pwm on time");
    $display("test pwm duty done");
    // Blink of the third fault output over one 80-cycle period
    third_fault_i <= 1'h1;
    for (int d = 0; d < 4; d++)
    begin
      wr(ADR[1], {d[1:0], 6'h04}, OKAY);
      cyc(80);
      n1 = 0;
      for (int k = 0; k < 80; k++)
      begin
        @(negedge mclk_i);
        n1 += pin_o[1] & pin_oe_o[1];
      end
      chk(n1, 16 >> d, "fault blink");
    end
    second_fault_i <= 1'h1;
    for (int t = 0; t < 4; t++)
    begin
      wr(ADR[1], PIN_CFG[t], OKAY);
      cyc(2);
      @(negedge mclk_i);
      chk({28'h0, pin_oe_o, pin_o & pin_oe_o}, {28'h0, PIN_EXP[t]}, "pin drive");
    end
    cyc(1);
    pin_in_i <= 2'h3;
    cyc(7);
    @(negedge mclk_i);
    chk({30'h0, pin_wake_o}, 32'h0, "wake early");
    cyc(1);
    @(negedge mclk_i);
    chk({30'h0, pin_wake_o}, 32'h3, "wake accepted");
    $display("test pins done");
    wr(ADR[0], 8'h11, OKAY);
    wr(ADR[5], 8'ha5, OKAY);
    restart_entry_i <= 1'h1;
    cyc(1);
    restart_entry_i <= 1'h0;
    rd_all(48'h002d_4040_04a5);
    soft_reset_i <= 1'h1;
    cyc(1);
    soft_reset_i <= 1'h0;
    rd_all(48'h0000_0000_00a5);
    normal_mode_i <= 1'h0;
    wr(ADR[5], 8'h3c, OKAY);
    rd(ADR[5], 8'h00, OKAY);
    normal_mode_i <= 1'h1;
    rd(ADR[5], 8'ha5, OKAY);
    {prot, wstrb} <= 7'h5e;
    wr(ADR[5], 8'h3c, OKAY);
    {prot, wstrb} <= 7'h0f;
    rd(ADR[5], 8'ha5, OKAY);
    rd(8'h00, 8'h00, spg_pkg::RESP_SLVERR);
    wr(8'h04, 8'hff, spg_pkg::RESP_SLVERR);
    reset_n_i <= 1'h0;
    cyc(2);
    reset_n_i <= 1'h1;
    rd(ADR[5], 8'h00, OKAY);
    $display("test resets and scratch done");
    wrap_up();
  end

  // Watchdog well beyond the few thousand cycles the sequence needs
  initial
  begin
    cyc(20000);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule

//--- tb/spg_host_model.sv
// Register-bus master standing in for the host microcontroller.
// Assumes an AXI4-Lite slave on the same clock; strobes and prot tied outside.
`timescale 1ns/1ps
module spg_host_model (
  input wire logic mclk_i,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus at time zero
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
  end

  // Ready is combinational, so it is looked at on the falling edge where it has settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, b;
    begin
      @(posedge mclk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {pa, pw, b} = 3'h6;
      while (!b)
      begin
        @(negedge mclk_i);
        pa = pa && !s_axi_awready;
        pw = pw && !s_axi_wready;
        b = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge mclk_i);
        s_axi_awvalid <= pa;
        s_axi_wvalid <= pw;
        s_axi_bready <= !b;
        s_axi_awaddr <= pa ? a : ~a;
        s_axi_wdata <= pw ? d : ~d;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, v;
    begin
      @(posedge mclk_i);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      {pa, v} = 2'h2;
      while (!v)
      begin
        @(negedge mclk_i);
        pa = pa && !s_axi_arready;
        v = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge mclk_i);
        s_axi_arvalid <= pa;
        s_axi_rready <= !v;
        s_axi_araddr <= pa ? a : ~a;
      end
    end
  endtask
endmodule
